// ===== dv/lpc_top_test.sv
// self-checking bench for the pixel clock generator configuration block.
// assumes lpc_top with an AXI4-Lite slave port and all outputs registered.
`timescale 1ns/1ps
module lpc_top_test;
  import lpc_pkg::*;
  // clock, reset and bus signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, tick, pll_on;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rd;
  logic ref_pin = 0, cha_pin = 0;
  int pin_cnt = 0, n_fail = 0, n_tests = 0, n;

  // compares with case equality so an unknown never matches
  `define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %0t %s got %h exp %h", $time, msg, got, exp); end end

  always #12.5 aclk = ~aclk;

  // free-running source pins: reference period 40 cycles, channel A period 8
  always @(posedge aclk) begin
    pin_cnt <= pin_cnt + 1;
    ref_pin <= (pin_cnt % 40) < 20;
    cha_pin <= (pin_cnt % 8) < 4;
  end

  lpc_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .external_reference_clock_input(ref_pin),
    .cha_hs_clock_input(cha_pin), .pixel_clock_tick(tick), .pll_enabled(pll_on)
  );

  // address and data offered together, each released at the edge that takes it;
  // no latency is assumed, only the watchdog ends a wait
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    // ready read right at an edge is the value the slave sampled there
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 0;
      end
    end
    // bready stands until bvalid is seen at an edge; the code is taken there
    do begin
      @(posedge aclk);
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_done;
    ar_done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    // arvalid and araddr stand until arready is seen at an edge
    while (!ar_done) begin
      @(posedge aclk);
      if (arready === 1'b1) begin
        ar_done = 1;
        arvalid <= 0;
      end
    end
    // rready stands until rvalid is seen; data and code taken at that edge
    do begin
      @(posedge aclk);
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  // write then check the response code
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, resp);
    `CHK(resp, RESP_OKAY, "write resp")
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_rd(a, rd, resp);
    `CHK(rd, e, "read data")
    `CHK(resp, er, "read resp")
  endtask

  task automatic count_ticks(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge aclk);
      if (tick === 1'b1) c++;
    end
  endtask

  // enable or disable, then look at the running flag once it has landed
  task automatic set_run(input bit on);
    wr_ok(ADDR_PLL, {31'h0, on});
    repeat (2) @(posedge aclk);
    `CHK(pll_on, logic'(on), "running flag")
  endtask

  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    #(25 * 20000);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    // reset values, and no output while disabled
    rd_chk(ADDR_SRC, 32'h0000000A, RESP_OKAY);
    rd_chk(ADDR_SCALE, 32'h00000000, RESP_OKAY);
    rd_chk(ADDR_PLL, 32'h00000000, RESP_OKAY);
    `CHK(pll_on, 1'b0, "running after reset")
    count_ticks(100, n);
    `CHK(n, 0, "ticks while disabled")
    $display("test reset_values done");

    // access kinds, byte strobe and an unmapped address
    wr_ok(ADDR_SRC, 32'hFFFFFFFF);
    rd_chk(ADDR_SRC, 32'h0000000F, RESP_OKAY);
    wr_ok(ADDR_SCALE, 32'hFFFFFFFF);
    rd_chk(ADDR_SCALE, 32'h000000FB, RESP_OKAY);
    wstrb <= 4'h0;
    wr_ok(ADDR_SCALE, 32'h00000000);
    wstrb <= 4'hF;
    rd_chk(ADDR_SCALE, 32'h000000FB, RESP_OKAY);
    axi_wr(8'h30, 32'h000000FF, resp);
    `CHK(resp, RESP_SLVERR, "unmapped write")
    rd_chk(8'h30, 32'h00000000, RESP_SLVERR);
    $display("test register_access done");

    // divide path: divide by 3 gives 10 ticks over 30 source edges;
    // the source pins run from time zero, so they are stable before any enable
    wr_ok(ADDR_SRC, 32'h00000001);
    wr_ok(ADDR_SCALE, 32'h00000010);
    set_run(1);
    rd_chk(ADDR_SRC, 32'h00000081, RESP_OKAY);
    // lock wait cut short: the tick model has no lock time
    repeat (40) @(posedge aclk);
    count_ticks(240, n);
    `CHK(n inside {[9:11]}, 1'b1, "divide by 3")
    // a change while running waits for the next enable
    wr_ok(ADDR_SCALE, 32'h00000000);
    count_ticks(240, n);
    `CHK(n inside {[9:11]}, 1'b1, "change while running")
    set_run(0);
    count_ticks(200, n);
    `CHK(n, 0, "ticks after disable")
    set_run(1);
    repeat (40) @(posedge aclk);
    count_ticks(240, n);
    `CHK(n inside {[29:31]}, 1'b1, "divide by 1")
    // reserved code behaves as divide by 25
    set_run(0);
    wr_ok(ADDR_SCALE, 32'h000000F8);
    set_run(1);
    repeat (40) @(posedge aclk);
    count_ticks(800, n);
    `CHK(n inside {[3:5]}, 1'b1, "reserved divide code")
    set_run(0);
    $display("test divide_path done");

    // multiply path: every code over ten reference periods
    wr_ok(ADDR_SRC, 32'h00000000);
    for (int m = 0; m < 4; m++) begin
      wr_ok(ADDR_SCALE, 32'(m));
      set_run(1);
      repeat (120) @(posedge aclk);
      count_ticks(400, n);
      `CHK(n inside {[(m + 1) * 10 - 2:(m + 1) * 10 + 2]}, 1'b1, "multiply")
      set_run(0);
    end
    $display("test multiply_path done");
    tally_and_finish();
  end
endmodule

// ===== hw/lpc_cfg_if.sv
// interface carrying the latched clock configuration from the register
// side to the clock generator, and the generator's running status back.
// assumes both ends run on the same aclk.
`timescale 1ns/1ps
interface lpc_cfg_if;
  logic src_sel;
  logic [4:0] div_code;
  logic [1:0] mult_code;
  logic run;
  logic active;

  modport ctl (output src_sel, output div_code, output mult_code, output run, input active);
  modport gen (input src_sel, input div_code, input mult_code, input run, output active);
endinterface

// ===== hw/lpc_clk_gen.sv
// pixel clock generator: turns the selected source clock pin into a
// one-cycle pixel clock tick, divided or multiplied as configured.
// assumes both source pins are asynchronous to aclk and slower than aclk/4.
`timescale 1ns/1ps
module lpc_clk_gen
  import lpc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // source clock pins
  input wire logic ref_clk_pin,
  input wire logic cha_clk_pin,
  // configuration
  lpc_cfg_if.gen cfg,
  // pixel clock tick
  output logic pix_tick
);

  lpc_gen_state_t state;
  lpc_gen_state_t next_state;
  logic [1:0] rise;
  logic [4:0] dcnt;
  logic [PERIOD_W-1:0] per_cnt;
  logic [PERIOD_W-1:0] period;
  logic [PERIOD_W-1:0] acc;
  logic [PERIOD_W-1:0] acc_sum;
  logic [4:0] div_eff;
  logic running;
  logic src_edge;
  logic div_hit;
  logic mult_hit;
  logic next_tick;

  // two-flop synchroniser per pin; flops live in each copy so each has one driver
  // the third flop feeds only the edge detector
  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic pin_q1;
    logic pin_q2;
    logic pin_q3;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_q1 <= 1'b0;
        pin_q2 <= 1'b0;
        pin_q3 <= 1'b0;
      end else begin
        pin_q1 <= (i == 0) ? ref_clk_pin : cha_clk_pin;
        pin_q2 <= pin_q1;
        pin_q3 <= pin_q2;
      end
    end
    assign rise[i] = pin_q2 & ~pin_q3;
  end

  // source selection and hit decoding
  assign running = (state == GEN_RUN);
  assign src_edge = cfg.src_sel ? rise[1] : rise[0]; // see (R01)
  // reserved divider codes behave as the largest legal one
  assign div_eff = (cfg.div_code > DIV_MAX) ? DIV_MAX : cfg.div_code;
  assign div_hit = rise[1] && (dcnt == div_eff); // see (R02)
  assign acc_sum = acc + PERIOD_W'(cfg.mult_code) + PERIOD_W'(1);
  assign mult_hit = (period != '0) && (acc_sum >= period); // see (R04)
  assign next_tick = running && (cfg.src_sel ? div_hit : mult_hit); // see (R01) (R10)
  assign next_state = cfg.run ? GEN_RUN : GEN_OFF; // see (R06)

  // state and tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= GEN_OFF;
      pix_tick <= 1'b0;
      cfg.active <= 1'b0;
    end else begin
      state <= next_state;
      pix_tick <= next_tick;
      cfg.active <= (next_state == GEN_RUN);
    end
  end

  // divider: counts channel A edges, tick on every (code+1)th
  always_ff @(posedge aclk) begin
    if (!aresetn || !running || !cfg.src_sel) begin
      dcnt <= 5'h00;
    end else if (rise[1]) begin
      dcnt <= div_hit ? 5'h00 : dcnt + 5'h01; // see (R02)
    end
  end

  // multiplier: measure the reference period, then spread (code+1) ticks over it
  // a single-period estimate trades jitter tolerance for tiny area
  always_ff @(posedge aclk) begin
    if (!aresetn || !running || cfg.src_sel) begin
      per_cnt <= '0;
      period <= '0;
      acc <= '0;
    end else if (src_edge) begin
      per_cnt <= '0;
      period <= per_cnt + PERIOD_W'(1);
      acc <= '0;
    end else begin
      per_cnt <= (per_cnt == '1) ? per_cnt : per_cnt + PERIOD_W'(1);
      if (period != '0) begin
        acc <= mult_hit ? acc_sum - period : acc_sum; // see (R04)
      end
    end
  end

  // tick stays low whenever the generator is off
  gen_off_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // see (R10)
    !cfg.run |=> ##1 !pix_tick)
    else $error("pixel tick while generator disabled");

  // divide mode: every tick comes from a channel A edge at the terminal count
  div_tick_cause_a: assert property (@(posedge aclk) disable iff (!aresetn) // see (R02)
    pix_tick && $past(cfg.src_sel) |-> $past(rise[1]) && $past(dcnt == div_eff))
    else $error("divide tick without terminal count");

  // divide mode: a non-terminal edge advances the count by one
  div_count_a: assert property (@(posedge aclk) disable iff (!aresetn) // see (R02)
    running && cfg.src_sel && rise[1] && !div_hit && $stable(cfg.run)
      |=> dcnt == $past(dcnt) + 5'h01)
    else $error("divider count did not advance");

  // multiply mode: a tick needs a measured period and an accumulator overflow
  mult_tick_cause_a: assert property (@(posedge aclk) disable iff (!aresetn) // see (R04)
    pix_tick && !$past(cfg.src_sel) |-> $past(period != '0) && $past(mult_hit))
    else $error("multiply tick without overflow");

endmodule

// ===== hw/lpc_pkg.sv
// package for the pixel clock generator configuration block:
// register indices, field positions, reset values and shared types.
// assumes an 8-bit byte address on the register bus.
package lpc_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_SRC = 8'h0A;
  localparam logic [7:0] IDX_SCALE = 8'h0B;
  localparam logic [7:0] IDX_PLL = 8'h0D;
  localparam logic [7:0] ADDR_SRC = 8'(IDX_SRC << 2);
  localparam logic [7:0] ADDR_SCALE = 8'(IDX_SCALE << 2);
  localparam logic [7:0] ADDR_PLL = 8'(IDX_PLL << 2);

  // field positions
  localparam int unsigned SRC_SEL_BIT = 0;
  localparam int unsigned RANGE_LSB = 1;
  localparam int unsigned RANGE_MSB = 3;
  localparam int unsigned STAT_BIT = 7;
  localparam int unsigned DIV_LSB = 3;
  localparam int unsigned DIV_MSB = 7;
  localparam int unsigned MULT_LSB = 0;
  localparam int unsigned MULT_MSB = 1;
  localparam int unsigned PLL_EN_BIT = 0;

  // reset values
  localparam logic SRC_SEL_RST = 1'b0;
  localparam logic [2:0] RANGE_RST = 3'h5;
  localparam logic [4:0] DIV_RST = 5'h00;
  localparam logic [1:0] MULT_RST = 2'h0;
  localparam logic PLL_EN_RST = 1'b0;

  // largest legal divider code (divide by 25)
  localparam logic [4:0] DIV_MAX = 5'h18;

  // width of the reference period measurement, in aclk cycles
  localparam int unsigned PERIOD_W = 16;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register selector returned by the address decoder
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_SRC = 2'h1,
    SEL_SCALE = 2'h2,
    SEL_PLL = 2'h3
  } lpc_sel_t;

  // generator state, one-hot
  typedef enum logic [1:0] {
    GEN_OFF = 2'b01,
    GEN_RUN = 2'b10
  } lpc_gen_state_t;

endpackage

// ===== hw/lpc_top.sv
// top of the pixel clock generator configuration block: AXI4-Lite slave
// with the source, scale and enable registers, driving the generator.
// assumes a single aclk at 40 MHz and source clock pins asynchronous to it.
`timescale 1ns/1ps
// What the document requires
// (R01) Source select 0 uses the reference clock pin, 1 uses channel A clock.
// (R02) On channel A, divider code plus one divides the source; codes above 24 reserved.
// (R03) Software writes divider zero when the reference clock is selected.
// (R04) On reference clock, multiplier code plus one multiplies the source.
// (R05) Software writes multiplier zero when channel A clock is selected.
// (R06) Setting enable starts the generator with the current settings; reset leaves it off.
// (R07) Software should clear enable before changing source or scale settings.
// (R08) The selected input clock must be stable before enable is set.
// (R09) After enabled status reads one, wait at least 3 ms before using the clock.
// (R10) While disabled, output stays inactive and setting changes take effect only at enable.
module lpc_top
  import lpc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // source clock pins
  input wire logic external_reference_clock_input,
  input wire logic cha_hs_clock_input,
  // generated pixel clock and status
  output logic pixel_clock_tick,
  output logic pll_enabled
);

  // decode a byte address into a register selector; used for reads and writes
  function automatic lpc_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    lpc_sel_t s;
    s = SEL_NONE;
    if (a == ADDR_SRC) begin
      s = SEL_SRC;
    end else if (a == ADDR_SCALE) begin
      s = SEL_SCALE;
    end else if (a == ADDR_PLL) begin
      s = SEL_PLL;
    end
    return s;
  endfunction

  lpc_cfg_if cfg ();

  // software-visible register fields
  logic pixel_clock_source_select;
  logic [2:0] clock_range;
  logic [4:0] cha_clock_divide_code;
  logic [1:0] external_clock_multiply_code;
  logic pll_enable;

  // captured write request
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;

  logic have_aw;
  logic have_w;
  logic do_write;
  lpc_sel_t wsel;
  lpc_sel_t rsel;
  logic [DATA_W-1:0] rd_word;
  logic next_pll_enable;
  logic enable_rise;
  logic write_src;
  logic write_scale;

  // prot bits carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[DATA_W-1:8], s_axi_wstrb[3:1]};

  // write path decoding; an address or data beat is held until the response is taken
  assign have_aw = !s_axi_awready && !s_axi_bvalid;
  assign have_w = !s_axi_wready && !s_axi_bvalid;
  assign do_write = have_aw && have_w;
  assign wsel = reg_sel(aw_addr);
  assign write_src = do_write && w_lane0 && (wsel == SEL_SRC);
  assign write_scale = do_write && w_lane0 && (wsel == SEL_SCALE);
  assign next_pll_enable = (do_write && w_lane0 && (wsel == SEL_PLL)) ?
    w_byte[PLL_EN_BIT] : pll_enable;
  assign enable_rise = next_pll_enable && !pll_enable; // see (R06)

  // read data selection; status bit shows the generator's own running state
  assign rsel = reg_sel(s_axi_araddr);
  always_comb begin
    rd_word = '0;
    unique case (rsel)
      SEL_SRC: begin
        rd_word[STAT_BIT] = cfg.active;
        rd_word[RANGE_MSB:RANGE_LSB] = clock_range;
        rd_word[SRC_SEL_BIT] = pixel_clock_source_select;
      end
      SEL_SCALE: begin
        rd_word[DIV_MSB:DIV_LSB] = cha_clock_divide_code;
        rd_word[MULT_MSB:MULT_LSB] = external_clock_multiply_code;
      end
      SEL_PLL: begin
        rd_word[PLL_EN_BIT] = pll_enable;
      end
      SEL_NONE: begin
        rd_word = '0;
      end
    endcase
  end

  // write address and data acceptance, response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: one read at a time, data latched with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pixel_clock_source_select <= SRC_SEL_RST; // see (R01)
      clock_range <= RANGE_RST;
      cha_clock_divide_code <= DIV_RST;
      external_clock_multiply_code <= MULT_RST;
      pll_enable <= PLL_EN_RST; // see (R06)
    end else begin
      if (write_src) begin
        pixel_clock_source_select <= w_byte[SRC_SEL_BIT];
        clock_range <= w_byte[RANGE_MSB:RANGE_LSB];
      end
      if (write_scale) begin
        cha_clock_divide_code <= w_byte[DIV_MSB:DIV_LSB];
        external_clock_multiply_code <= w_byte[MULT_MSB:MULT_LSB];
      end
      pll_enable <= next_pll_enable;
    end
  end

  // settings reach the generator only at the enable edge, so edits made
  // while running or disabled never glitch the output clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.src_sel <= SRC_SEL_RST;
      cfg.div_code <= DIV_RST;
      cfg.mult_code <= MULT_RST;
      cfg.run <= PLL_EN_RST;
    end else begin
      cfg.run <= next_pll_enable; // see (R06)
      if (enable_rise) begin
        cfg.src_sel <= write_src ? w_byte[SRC_SEL_BIT] : pixel_clock_source_select; // see (R10)
        cfg.div_code <= write_scale ? w_byte[DIV_MSB:DIV_LSB] : cha_clock_divide_code;
        cfg.mult_code <= write_scale ? w_byte[MULT_MSB:MULT_LSB] : external_clock_multiply_code;
      end
    end
  end

  lpc_clk_gen u_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_clk_pin(external_reference_clock_input),
    .cha_clk_pin(cha_hs_clock_input),
    .cfg(cfg.gen),
    .pix_tick(pixel_clock_tick)
  );

  assign pll_enabled = cfg.active;

  // enabling: the generator sees run in the same cycle as the enable register,
  // and reports active one cycle after that
  sequence s_enable_written;
    $rose(pll_enable);
  endsequence
  sequence s_generator_up;
    cfg.run ##1 cfg.active;
  endsequence

  enable_start_a: assert property (@(posedge aclk) disable iff (!aresetn) // see (R06)
    s_enable_written ##0 pll_enable[*2] |-> s_generator_up)
    else $error("generator did not start after enable");

  // at the enable edge the generator takes the stored source select
  cfg_latch_a: assert property (@(posedge aclk) disable iff (!aresetn) // see (R06)
    $rose(cfg.run) |-> cfg.src_sel == $past(
      write_src ? w_byte[SRC_SEL_BIT] : pixel_clock_source_select))
    else $error("source select not latched at enable");

  // settings seen by the generator hold still until the next enable
  cfg_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // see (R10)
    !$rose(cfg.run) |-> $stable(cfg.div_code) && $stable(cfg.mult_code) && $stable(cfg.src_sel))
    else $error("generator settings changed without enable");

  // disabling: status drops one cycle after the enable register clears
  disable_status_a: assert property (@(posedge aclk) disable iff (!aresetn) // see (R10)
    $fell(pll_enable) ##0 !pll_enable[*2] |-> !pll_enabled)
    else $error("status still enabled after disable");

endmodule
